// File: design/ssd_consts.svh
/*
 constants of the step/direction input logic: register offsets, field positions, reset values and timing counts.
 assumes it is included by bare name from the design files of this block only.
*/
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH

// clock and link timing
`define SSD_CLK_HZ 50000000
`define SSD_PWM_MIN_HZ 15000
`define SSD_PWM_MAX_HZ 25000
// no pwm edge for two slowest periods means the line is stuck
`define SSD_PWM_TO_CYC ((2 * `SSD_CLK_HZ) / `SSD_PWM_MIN_HZ)

// register byte offsets
`define SSD_REG_CTRL 8'h00
`define SSD_REG_STEP_SIZE 8'h04
`define SSD_REG_SPEED1 8'h08
`define SSD_REG_SPEED2 8'h0C
`define SSD_REG_POS0 8'h10
`define SSD_REG_POS1 8'h14
`define SSD_REG_STATUS 8'h18
`define SSD_REG_DUTY 8'h1C

// control fields
`define SSD_CTRL_MODE_BIT 0
`define SSD_CTRL_POL_LSB 1
`define SSD_CTRL_INT_LSB 3

// reset values
`define SSD_CTRL_RST 5'h00
`define SSD_STEP_SIZE_RST 16'h0101
`define SSD_SPEED_RST 32'h0000_0000

// internal step generator
`define SSD_ACC_W 24
`define SSD_DUTY_W 14
`define SSD_PWM_GAIN_SH 4

`endif

// File: design/ssd_pkg.sv
/*
 types shared by the step/direction input logic.
 assumes the constants header is compiled alongside.
*/
package ssd_pkg;

    typedef enum logic [0:0]
    {
        SSD_MODE_VOLT = 1'b0,
        SSD_MODE_PWM = 1'b1
    } ssd_speed_mode_t;

    typedef logic [15:0] ssd_rate_t;

endpackage : ssd_pkg

// File: design/ssd_pwm_meas.sv
/*
 pwm duty measurement: latches the high time of each pwm period in clock cycles, less the rising cycle, which is not counted.
 assumes a synchronised pwm level; a line that stops toggling reads as 0 or full scale.
*/
`timescale 1ns/1ps
`include "ssd_consts.svh"

module ssd_pwm_meas #(
    parameter int CNT_W = `SSD_DUTY_W,
    parameter int TO_CYC = `SSD_PWM_TO_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pwm_s,
    output logic [CNT_W-1:0] duty_q
);

    logic lvl_q;
    logic [CNT_W-1:0] hi_cnt_q;
    logic [CNT_W-1:0] per_cnt_q;

    wire logic rise = pwm_s & ~lvl_q;
    wire logic stuck = (per_cnt_q == CNT_W'(TO_CYC));

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            lvl_q <= 1'b0;
            hi_cnt_q <= '0;
            per_cnt_q <= '0;
            duty_q <= '0;
        end
        else
        begin
            lvl_q <= pwm_s;
            if (rise)
            begin
                duty_q <= hi_cnt_q;
                hi_cnt_q <= '0;
                per_cnt_q <= '0;
            end
            else if (stuck)
            begin
                duty_q <= pwm_s ? '1 : '0;
                hi_cnt_q <= '0;
                per_cnt_q <= '0;
            end
            else
            begin
                per_cnt_q <= per_cnt_q + CNT_W'(1);
                hi_cnt_q <= hi_cnt_q + CNT_W'(pwm_s);
            end
        end
    end

endmodule : ssd_pwm_meas

// File: design/ssd_step_dir.sv
/*
 step/direction input logic of a dual-axis stepper driver with speed control.
 assumes isolated inputs arrive as levels where 1 means the circuit is closed,
 and a register master that keeps the plain strobe protocol on clk_sys.
*/
`timescale 1ns/1ps
`include "ssd_consts.svh"

module ssd_step_dir #(
    parameter int POS_W = 32,
    parameter int PWM_TO_CYC = `SSD_PWM_TO_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] step_in,
    input wire logic [1:0] dir_in,
    input wire logic [1:0] speed_sel_in,
    input wire logic [1:0] pwm_in,
    input wire logic [1:0] run_in,
    input wire logic [1:0] disable_in,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata_q,
    output logic [1:0] step_rpt_q,
    output logic [1:0] dir_rpt_q,
    output logic [1:0] drv_en_q,
    output logic [1:0] int_step_q,
    output logic [2*POS_W-1:0] drv_pos_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisation

    logic [11:0] in_s;

    ssd_sync #(
        .W(12)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({disable_in, run_in, pwm_in, speed_sel_in, dir_in, step_in}),
        .sync_q(in_s)
    );

    wire logic [1:0] step_s = in_s[1:0];
    wire logic [1:0] dir_s = in_s[3:2];
    wire logic [1:0] sel_s = in_s[5:4];
    wire logic [1:0] pwm_s = in_s[7:6];
    wire logic [1:0] run_s = in_s[9:8];
    wire logic [1:0] dis_s = in_s[11:10];

    ////////////////////////////////////////////////////////////////////////////////
    // software registers

    logic [4:0] ctrl_q;
    logic [15:0] step_size_q;
    logic [31:0] speed1_q;
    logic [31:0] speed2_q;

    wire logic wr_ctrl = bus_wr && (bus_addr == `SSD_REG_CTRL);
    wire logic wr_size = bus_wr && (bus_addr == `SSD_REG_STEP_SIZE);
    wire logic wr_spd1 = bus_wr && (bus_addr == `SSD_REG_SPEED1);
    wire logic wr_spd2 = bus_wr && (bus_addr == `SSD_REG_SPEED2);
    wire logic [1:0] wr_pos = {bus_wr && (bus_addr == `SSD_REG_POS1), bus_wr && (bus_addr == `SSD_REG_POS0)};

    wire ssd_pkg::ssd_speed_mode_t mode = ssd_pkg::ssd_speed_mode_t'(ctrl_q[`SSD_CTRL_MODE_BIT]);
    wire logic [1:0] pol = ctrl_q[`SSD_CTRL_POL_LSB +: 2];
    wire logic [1:0] use_int = ctrl_q[`SSD_CTRL_INT_LSB +: 2];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `SSD_CTRL_RST;
            step_size_q <= `SSD_STEP_SIZE_RST;
            speed1_q <= `SSD_SPEED_RST;
            speed2_q <= `SSD_SPEED_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= bus_wdata[4:0];
            end
            if (wr_size)
            begin
                step_size_q <= bus_wdata[15:0];
            end
            if (wr_spd1)
            begin
                speed1_q <= bus_wdata;
            end
            if (wr_spd2)
            begin
                speed2_q <= bus_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // rate helpers

    // pwm high time in cycles scaled to a phase increment, saturating
    function automatic ssd_pkg::ssd_rate_t pwm_to_rate(input logic [`SSD_DUTY_W-1:0] duty);
        logic [`SSD_DUTY_W+`SSD_PWM_GAIN_SH-1:0] wide;
        wide = {duty, {`SSD_PWM_GAIN_SH{1'b0}}};
        if (wide > (`SSD_DUTY_W+`SSD_PWM_GAIN_SH)'(16'hFFFF))
        begin
            pwm_to_rate = 16'hFFFF;
        end
        else
        begin
            pwm_to_rate = wide[15:0];
        end
    endfunction : pwm_to_rate

    ////////////////////////////////////////////////////////////////////////////////
    // per-axis stepping

    logic [POS_W-1:0] pos_w [2];
    logic [`SSD_DUTY_W-1:0] duty_w [2];

    genvar ax;
    generate
        for (ax = 0; ax < 2; ax++)
        begin : g_axis
            logic step_prev_q;
            logic [`SSD_ACC_W-1:0] acc_q;
            logic int_pulse_q;
            logic [POS_W-1:0] pos_q;
            logic rpt_step_q;
            logic rpt_dir_q;
            logic en_q;
            logic [POS_W-1:0] shown_q;

            ssd_pwm_meas #(
                .CNT_W(`SSD_DUTY_W),
                .TO_CYC(PWM_TO_CYC)
            ) u_pwm (
                .clk_sys(clk_sys),
                .rst(rst),
                .pwm_s(pwm_s[ax]),
                .duty_q(duty_w[ax])
            );

            wire ssd_pkg::ssd_rate_t spd1 = speed1_q[16*ax +: 16];
            wire ssd_pkg::ssd_rate_t spd2 = speed2_q[16*ax +: 16];
            wire ssd_pkg::ssd_rate_t volt_rate = sel_s[ax] ? spd2 : spd1;
            wire ssd_pkg::ssd_rate_t rate = (mode == ssd_pkg::SSD_MODE_PWM) ?
                pwm_to_rate(duty_w[ax]) : volt_rate;
            wire logic [`SSD_ACC_W:0] acc_sum = {1'b0, acc_q} + {{(`SSD_ACC_W-15){1'b0}}, rate};

            wire logic open_edge = step_prev_q & ~step_s[ax];
            wire logic advance = use_int[ax] ? int_pulse_q : open_edge;
            wire logic cw = dir_s[ax] ^ pol[ax];
            wire logic [POS_W-1:0] amt = POS_W'(step_size_q[8*ax +: 8]);
            wire logic [POS_W-1:0] pos_step = cw ? (pos_q + amt) : (pos_q - amt);

            // internal step clock: phase accumulator, held clear while run is open
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    acc_q <= '0;
                    int_pulse_q <= 1'b0;
                end
                else if (!run_s[ax])
                begin
                    acc_q <= '0;
                    int_pulse_q <= 1'b0;
                end
                else
                begin
                    acc_q <= acc_sum[`SSD_ACC_W-1:0];
                    int_pulse_q <= acc_sum[`SSD_ACC_W];
                end
            end

            // position counts regardless of the driver disable
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    step_prev_q <= 1'b0;
                    pos_q <= '0;
                end
                else
                begin
                    step_prev_q <= step_s[ax];
                    if (wr_pos[ax])
                    begin
                        pos_q <= POS_W'(bus_wdata);
                    end
                    else if (advance)
                    begin
                        pos_q <= pos_step;
                    end
                end
            end

            // repeat outputs and driver view of the position
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    rpt_step_q <= 1'b0;
                    rpt_dir_q <= 1'b0;
                    en_q <= 1'b0;
                    shown_q <= '0;
                end
                else
                begin
                    rpt_step_q <= step_s[ax];
                    rpt_dir_q <= cw;
                    en_q <= ~dis_s[ax];
                    if (!dis_s[ax])
                    begin
                        shown_q <= pos_q;
                    end
                end
            end

            assign pos_w[ax] = pos_q;
            assign step_rpt_q[ax] = rpt_step_q;
            assign dir_rpt_q[ax] = rpt_dir_q;
            assign drv_en_q[ax] = en_q;
            assign int_step_q[ax] = int_pulse_q;
            assign drv_pos_q[POS_W*ax +: POS_W] = shown_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register read-back

    wire logic [31:0] status_w = {16'h0000, 4'h0, in_s};
    wire logic [31:0] duty_rd = {2'b00, duty_w[1], 2'b00, duty_w[0]};

    logic [31:0] rd_mux;

    always_comb
    begin
        unique case (bus_addr)
            `SSD_REG_CTRL: rd_mux = {27'h000_0000, ctrl_q};
            `SSD_REG_STEP_SIZE: rd_mux = {16'h0000, step_size_q};
            `SSD_REG_SPEED1: rd_mux = speed1_q;
            `SSD_REG_SPEED2: rd_mux = speed2_q;
            `SSD_REG_POS0: rd_mux = 32'(pos_w[0]);
            `SSD_REG_POS1: rd_mux = 32'(pos_w[1]);
            `SSD_REG_STATUS: rd_mux = status_w;
            `SSD_REG_DUTY: rd_mux = duty_rd;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            bus_rdata_q <= 32'h0000_0000;
        end
        else
        begin
            bus_rdata_q <= bus_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : ssd_step_dir

// File: design/ssd_sync.sv
/*
 two-stage synchroniser for a group of isolated input levels.
 assumes inputs may change at any time relative to clk_sys.
*/
`timescale 1ns/1ps

module ssd_sync #(
    parameter int W = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule : ssd_sync

// File: dv/ssd_mc_model.sv
/*
 motion controller model: step, direction and pwm levels, 1 = closed.
 assumes calls from the bench right after a rising edge of clk_sys.
*/
`timescale 1ns/1ps
module ssd_mc_model (
    input wire logic clk_sys,
    output logic [1:0] step_o,
    output logic [1:0] dir_o,
    output logic [1:0] pwm_o
);
    int pwm_hi = 0;
    initial
    begin
        step_o = 2'h0;
        dir_o = 2'h0;
        pwm_o = 2'h0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic pulse(input int ax, input logic d, input int len);
        @(posedge clk_sys);
        dir_o[ax] <= d;
        repeat (3) @(posedge clk_sys);
        step_o[ax] <= 1'b1;
        repeat (len) @(posedge clk_sys);
        step_o[ax] <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : pulse
    // period of 100 cycles on axis 0, high for pwm_hi cycles
    always
    begin
        repeat (100 - pwm_hi) @(posedge clk_sys);
        if (pwm_hi != 0)
        begin
            pwm_o[0] <= 1'b1;
            repeat (pwm_hi) @(posedge clk_sys);
            pwm_o[0] <= 1'b0;
        end
    end
endmodule : ssd_mc_model

// File: dv/ssd_step_dir_properties.sv
/*
 port assertions of the step/direction block.
 assumes a bind to ssd_step_dir, one clock domain.
*/
`timescale 1ns/1ps
module ssd_step_dir_chk #(
    parameter int POS_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] step_in,
    input wire logic [1:0] dir_in,
    input wire logic [1:0] speed_sel_in,
    input wire logic [1:0] pwm_in,
    input wire logic [1:0] run_in,
    input wire logic [1:0] disable_in,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata_q,
    input wire logic [1:0] step_rpt_q,
    input wire logic [1:0] dir_rpt_q,
    input wire logic [1:0] drv_en_q,
    input wire logic [1:0] int_step_q,
    input wire logic [2*POS_W-1:0] drv_pos_q
);
    logic [1:0] up_q;
    // sync chain is full once three edges passed reset
    wire logic ok = up_q == 2'h3;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    sequence open0_s;
        (ok && step_in[0]) ##1 !step_in[0];
    endsequence
    step_open_a: assert property (open0_s |-> ##2 step_rpt_q[0] ##1 !step_rpt_q[0])
        else $error("step repeat missed an opening edge");
    step_rpt_a: assert property (ok |-> step_rpt_q == $past(step_in, 3))
        else $error("step repeat differs from input");
    drv_en_a: assert property (ok |-> drv_en_q == ~$past(disable_in, 3))
        else $error("driver enable wrong");
    rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata_q == 32'h0)
        else $error("read data outside read slot");
    rd_unmap_a: assert property ($past(bus_rd) && $past(bus_addr) > 8'h1C |-> bus_rdata_q == 32'h0)
        else $error("unmapped read not zero");
    int_pulse_a: assert property (int_step_q[0] |=> !int_step_q[0])
        else $error("internal step longer than one cycle");
    run_gate_a: assert property (ok && !$past(run_in[0], 3) && !$past(run_in[0], 4) |-> !int_step_q[0])
        else $error("internal step while run open");
    pos_hold_a: assert property (ok && $past(disable_in[0], 3) && $past(disable_in[0], 4)
        |-> $stable(drv_pos_q[POS_W-1:0]))
        else $error("driver position moved while disabled");
endmodule : ssd_step_dir_chk
bind ssd_step_dir ssd_step_dir_chk #(.POS_W(POS_W)) chk_i (.clk_sys(clk_sys), .rst(rst), .step_in(step_in),
    .dir_in(dir_in), .speed_sel_in(speed_sel_in), .pwm_in(pwm_in), .run_in(run_in), .disable_in(disable_in),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .step_rpt_q(step_rpt_q), .dir_rpt_q(dir_rpt_q), .drv_en_q(drv_en_q), .int_step_q(int_step_q),
    .drv_pos_q(drv_pos_q));

// File: dv/ssd_step_dir_tb_top.sv
/*
 self-checking bench of the step/direction block.
 assumes the controller model and checker are compiled first.
*/
`timescale 1ns/1ps
module ssd_step_dir_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] speed_sel_in = 2'h0;
    logic [1:0] run_in = 2'h0;
    logic [1:0] disable_in = 2'h0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic rd_seen = 1'b0;
    logic [1:0] step_in, dir_in, pwm_in, step_rpt_q, dir_rpt_q, drv_en_q, int_step_q, pl;
    logic [31:0] bus_rdata_q, old;
    logic [63:0] drv_pos_q;
    logic [31:0] exp_q[$];
    logic [31:0] pos_e [2] = '{32'h0, 32'h0};
    logic [7:0] sz [2];
    int pc [3] = '{8, 2, 0};
    int miscompares = 0;
    int check_count = 0;
    int pcnt = 0;
    int k, n;
    always #10 clk_sys = ~clk_sys;
    ssd_step_dir #(.POS_W(32), .PWM_TO_CYC(200)) dut (.clk_sys(clk_sys), .rst(rst), .step_in(step_in),
        .dir_in(dir_in), .speed_sel_in(speed_sel_in), .pwm_in(pwm_in), .run_in(run_in), .disable_in(disable_in),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
        .step_rpt_q(step_rpt_q), .dir_rpt_q(dir_rpt_q), .drv_en_q(drv_en_q), .int_step_q(int_step_q),
        .drv_pos_q(drv_pos_q));
    ssd_mc_model mc (.clk_sys(clk_sys), .step_o(step_in), .dir_o(dir_in), .pwm_o(pwm_in));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        exp_q.push_back(e);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
    endtask : rd
    task automatic stp(input int ax, input logic d);
        mc.pulse(ax, d, 1 + $urandom % 3);
        pos_e[ax] = (d ^ pl[ax]) ? pos_e[ax] + 32'(sz[ax]) : pos_e[ax] - 32'(sz[ax]);
    endtask : stp
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    // read data stands in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        rd_seen <= bus_rd;
        if (rd_seen)
            chk("rdata", bus_rdata_q, exp_q.pop_front());
    end
    always @(negedge clk_sys)
        if (int_step_q[0] === 1'b1)
            pcnt++;
    initial
    begin
        cyc(100000);
        miscompares++;
        results();
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        k = $urandom(9);
        pl = 2'h0;
        cyc(16);
        rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0000_0101);
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0);
        $display("test reset done");
        sz[0] = 8'($urandom);
        sz[1] = 8'($urandom);
        wr(8'h04, {16'h0, sz[1], sz[0]});
        for (k = 0; k < 6; k++)
            stp(k % 2, k < 3);
        rd(8'h10, pos_e[0]);
        rd(8'h14, pos_e[1]);
        pl = 2'h1;
        wr(8'h00, 32'h0000_0002);
        stp(0, 1'b1);
        rd(8'h10, pos_e[0]);
        chk("dir_rpt", {30'h0, dir_rpt_q}, {30'h0, dir_in ^ pl});
        pos_e[0] = 32'hFFFF_FFFF;
        wr(8'h10, pos_e[0]);
        stp(0, 1'b0);
        rd(8'h10, pos_e[0]);
        $display("test steps done");
        old = pos_e[0];
        disable_in <= 2'h1;
        cyc(4);
        rd(8'h18, 32'h0000_0400);
        stp(0, 1'b0);
        chk("drv_en", {30'h0, drv_en_q}, 32'h2);
        chk("drv_pos", drv_pos_q[31:0], old);
        rd(8'h10, pos_e[0]);
        disable_in <= 2'h0;
        cyc(5);
        chk("drv_pos", drv_pos_q[31:0], pos_e[0]);
        chk("drv_pos1", drv_pos_q[63:32], pos_e[1]);
        chk("drv_en", {30'h0, drv_en_q}, 32'h3);
        $display("test disable done");
        wr(8'h08, 32'h0000_8000);
        wr(8'h0C, 32'h0000_2000);
        wr(8'h00, 32'h0000_000A);
        for (k = 0; k < 3; k++)
        begin
            run_in <= 2'h0;
            speed_sel_in <= {1'b0, k == 1};
            cyc(8);
            run_in <= {1'b0, k != 2};
            n = pcnt;
            cyc(4146);
            chk("pulses", 32'(pcnt - n), 32'(pc[k]));
        end
        $display("test voltage speed done");
        run_in <= 2'h0;
        speed_sel_in <= 2'h1;
        mc.pwm_hi = 96;
        wr(8'h00, 32'h0000_000B);
        cyc(400);
        // 96 high cycles per period; the rising cycle itself is not counted
        rd(8'h1C, 32'h0000_005F);
        run_in <= 2'h1;
        n = pcnt;
        cyc(12000);
        chk("pulses", 32'(pcnt - n), 32'h1);
        $display("test pwm speed done");
        results();
    end
endmodule : ssd_step_dir_tb_top
